// [hdl/byte_alu_arith_logic.sv]
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ba_defines.svh"

// Function
// [RULE1] byte operand comes from direct, indirect, register or immediate source
// [RULE2] arithmetic ops take 1 us; data pointer increment 2 us; multiply/divide 4 us
// [RULE3] increment/decrement any memory byte without touching the accumulator
// [RULE4] data pointer increments as one 16-bit value with carry into high byte
// [RULE5] multiply acc by aux unsigned; high byte to aux, low byte to acc
// [RULE6] divide acc by aux unsigned; quotient to acc, remainder to aux
// [RULE7] add-with-carry adds acc, operand and carry; plain add ignores carry
// [RULE8] subtract-with-borrow takes acc minus operand minus carry
// [RULE9] bcd fixup corrects acc after adding two packed bcd bytes
// [RULE10] and, or, xor, complement work bit by bit
// [RULE11] and/or/xor may target a direct byte with acc or immediate, acc kept
// [RULE12] accumulator logic ops take 1 us; direct byte with immediate takes 2 us
// [RULE13] clear loads zero, complement inverts acc, each in one period
// [RULE14] rotates move acc one bit, wrapping the end bit around
// [RULE15] rotates through carry include carry; bit shifted out lands in carry
// [RULE16] nibble exchange swaps acc halves in one period
// [RULE17] parity flag always shows odd count of ones in acc
// [RULE18] working registers resolve in the bank chosen by two bank select bits
// [RULE19] indirect address comes only from pointer register zero or one
// [RULE20] add/sum_carry_op/minus_borrow_op set carry, half-carry, overflow from bit 7, bit 3, sign
// [RULE21] fixup adds six per nibble above nine or on carry, carry set on overflow
// [RULE22] multiply/divide clear carry; overflow on product above 255 or divide by zero
module byte_alu_arith_logic
  import ba_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic aluBusy
);
  import ba_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // architectural state
  logic [7:0] acc;
  logic [7:0] aux;
  logic [7:0] flags;
  logic [15:0] data_pointer;
  logic [7:0] ram [0:127];
  logic [7:0] operand;
  logic [7:0] lastResult;
  ba_state_t state;
  logic [9:0] cycCount;
  logic [31:0] cmd;
  logic cmdErr;

  wire ba_op_t opCode = ba_op_t'(cmd[`BA_CMD_OP_LSB +: 5]);
  wire ba_mode_t opMode = ba_mode_t'(cmd[`BA_CMD_MODE_LSB +: 2]);
  wire [7:0] opAddr = cmd[`BA_CMD_ADDR_LSB +: 8];
  wire [7:0] opImm = cmd[`BA_CMD_IMM_LSB +: 8];
  wire bank_sel_low = flags[`BA_FLG_RS0];
  wire bank_sel_high = flags[`BA_FLG_RS1];
  wire carryIn = flags[`BA_FLG_CY];
  wire parity = ^acc; // [RULE17]

  // register index inside the selected bank
  function automatic logic [6:0] bankAddr(input logic [1:0] bank, input logic [2:0] idx);
    bankAddr = {2'b00, bank, idx};
  endfunction

  wire [1:0] bank = {bank_sel_high, bank_sel_low};
  wire [7:0] pointer_reg_zero = ram[bankAddr(bank, 3'h0)]; // [RULE18]
  wire [7:0] pointer_reg_one = ram[bankAddr(bank, 3'h1)];
  // only bit 0 of the address field picks the pointer register
  wire [7:0] indAddr = opAddr[0] ? pointer_reg_one : pointer_reg_zero; // [RULE19]
  wire [6:0] regAddr = bankAddr(bank, opAddr[2:0]); // [RULE18]
  // effective memory address; upper half has no memory here and reads zero
  wire [7:0] effAddr = (opMode == BA_M_IND) ? indAddr :
                       (opMode == BA_M_REG) ? {1'b0, regAddr} : opAddr;
  wire memHit = ~effAddr[7];
  wire [7:0] memByte = memHit ? ram[effAddr[6:0]] : 8'h00;
  wire [7:0] srcByte = (opMode == BA_M_IMM) ? opImm : memByte; // [RULE1]

  ////////////////////////////////////////////////////////////////////////////
  // datapath
  wire sum_carry_op = (opCode == BA_SUM_CARRY_OP);
  wire cyIn = sum_carry_op & carryIn; // [RULE7]
  wire [8:0] addSum = {1'b0, acc} + {1'b0, srcByte} + {8'h00, cyIn}; // [RULE7]
  wire [4:0] addLow = {1'b0, acc[3:0]} + {1'b0, srcByte[3:0]} + {4'h0, cyIn};
  wire [8:0] subDiff = {1'b0, acc} - {1'b0, srcByte} - {8'h00, carryIn}; // [RULE8]
  wire [4:0] subLow = {1'b0, acc[3:0]} - {1'b0, srcByte[3:0]} - {4'h0, carryIn};
  wire addOv = (acc[7] == srcByte[7]) && (addSum[7] != acc[7]); // [RULE20]
  wire subOv = (acc[7] != srcByte[7]) && (subDiff[7] != acc[7]); // [RULE20]

  wire [15:0] product = {8'h00, acc} * {8'h00, aux}; // [RULE5]
  wire divZero = (aux == 8'h00);
  wire [7:0] quotient = divZero ? 8'h00 : acc / aux; // [RULE6]
  wire [7:0] remainder = divZero ? 8'h00 : acc % aux; // [RULE6]

  // [RULE21]
  wire lowFix = (acc[3:0] > 4'h9) | flags[`BA_FLG_AC];
  wire [8:0] daStep1 = {1'b0, acc} + (lowFix ? 9'h006 : 9'h000);
  wire hiFix = (daStep1[7:4] > 4'h9) | carryIn | daStep1[8];
  wire [8:0] daStep2 = {1'b0, daStep1[7:0]} + (hiFix ? 9'h060 : 9'h000);
  wire daCarry = carryIn | daStep1[8] | daStep2[8];

  wire [7:0] logicSrc = (opCode == BA_ANDMI || opCode == BA_ORMI || opCode == BA_XORMI) ?
                        opImm : acc; // [RULE11]
  wire [7:0] memAnd = memByte & logicSrc; // [RULE10]
  wire [7:0] memOr = memByte | logicSrc;
  wire [7:0] memXor = memByte ^ logicSrc;

  logic [7:0] next_acc;
  logic [7:0] next_aux;
  logic [7:0] next_flags;
  logic [15:0] next_data_pointer;
  logic [7:0] next_mem;
  logic memWrite;
  logic [9:0] opCycles;

  always_comb begin
    next_acc = acc;
    next_aux = aux;
    next_flags = flags;
    next_data_pointer = data_pointer;
    next_mem = memByte;
    memWrite = 1'b0;
    opCycles = 10'(`BA_CYC_SHORT); // [RULE2]
    unique case (opCode)
      BA_ADD, BA_SUM_CARRY_OP: begin
        next_acc = addSum[7:0];
        next_flags[`BA_FLG_CY] = addSum[8]; // [RULE20]
        next_flags[`BA_FLG_AC] = addLow[4];
        next_flags[`BA_FLG_OV] = addOv;
      end
      BA_MINUS_BORROW_OP: begin
        next_acc = subDiff[7:0];
        next_flags[`BA_FLG_CY] = subDiff[8]; // [RULE20]
        next_flags[`BA_FLG_AC] = subLow[4];
        next_flags[`BA_FLG_OV] = subOv;
      end
      BA_INCA: next_acc = acc + 8'h01;
      BA_DECA: next_acc = acc - 8'h01;
      BA_INCM: begin
        next_mem = memByte + 8'h01; // [RULE3]
        memWrite = 1'b1;
      end
      BA_DECM: begin
        next_mem = memByte - 8'h01; // [RULE3]
        memWrite = 1'b1;
      end
      BA_INCDP: begin
        next_data_pointer = data_pointer + 16'h0001; // [RULE4]
        opCycles = 10'(`BA_CYC_DATA_POINTER); // [RULE2]
      end
      BA_MUL: begin
        next_acc = product[7:0]; // [RULE5]
        next_aux = product[15:8];
        next_flags[`BA_FLG_CY] = 1'b0; // [RULE22]
        next_flags[`BA_FLG_OV] = |product[15:8];
        opCycles = 10'(`BA_CYC_MULDIV); // [RULE2]
      end
      BA_DIV: begin
        next_acc = quotient; // [RULE6]
        next_aux = remainder;
        next_flags[`BA_FLG_CY] = 1'b0; // [RULE22]
        next_flags[`BA_FLG_OV] = divZero;
        opCycles = 10'(`BA_CYC_MULDIV); // [RULE2]
      end
      BA_DAA: begin
        next_acc = daStep2[7:0]; // [RULE9]
        next_flags[`BA_FLG_CY] = daCarry; // [RULE21]
      end
      BA_ANDA: next_acc = acc & srcByte; // [RULE10]
      BA_ORA: next_acc = acc | srcByte;
      BA_XORA: next_acc = acc ^ srcByte;
      BA_ANDM, BA_ANDMI: begin
        next_mem = memAnd; // [RULE11]
        memWrite = 1'b1;
      end
      BA_ORM, BA_ORMI: begin
        next_mem = memOr; // [RULE11]
        memWrite = 1'b1;
      end
      BA_XORM, BA_XORMI: begin
        next_mem = memXor; // [RULE11]
        memWrite = 1'b1;
      end
      BA_CLR: next_acc = `BA_RST_BYTE; // [RULE13]
      BA_CPL: next_acc = ~acc; // [RULE13]
      BA_RL: next_acc = {acc[6:0], acc[7]}; // [RULE14]
      BA_RR: next_acc = {acc[0], acc[7:1]}; // [RULE14]
      BA_RLC: begin
        next_acc = {acc[6:0], carryIn}; // [RULE15]
        next_flags[`BA_FLG_CY] = acc[7];
      end
      BA_RRC: begin
        next_acc = {carryIn, acc[7:1]}; // [RULE15]
        next_flags[`BA_FLG_CY] = acc[0];
      end
      BA_SWAP: next_acc = {acc[3:0], acc[7:4]}; // [RULE16]
      default: ;
    endcase
    // the immediate direct-byte logic forms need a second operand fetch
    if (opCode == BA_ANDMI || opCode == BA_ORMI || opCode == BA_XORMI) begin
      opCycles = 10'(`BA_CYC_LOGIMM); // [RULE12]
    end
    next_flags[`BA_FLG_P] = ^next_acc; // [RULE17]
  end

  // direct logic destinations only reach the lower memory; upper half is dropped
  wire memDest = (opCode == BA_ANDM || opCode == BA_ORM || opCode == BA_XORM ||
                  opCode == BA_ANDMI || opCode == BA_ORMI || opCode == BA_XORMI);
  wire badMode = memDest && (opMode != BA_M_DIR);
  wire legalOp = (opCode <= BA_SWAP) && !badMode;

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave: one outstanding write and read
  logic awHeld;
  logic wHeld;
  logic [11:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  wire doWrite = awHeld && wHeld && !s_axi_bvalid;
  wire wrCmd = doWrite && (awAddr == `BA_REG_CMD);
  wire wrRam = doWrite && (awAddr >= `BA_RAM_BASE) && (awAddr < 12'h300);
  // window starts at 0x100, so flipping bit 8 turns the word offset into byte 0..127
  wire [6:0] wrRamIdx = {~awAddr[8], awAddr[7:2]};
  wire wrKnown = wrRam || (awAddr == `BA_REG_CMD) || (awAddr == `BA_REG_OPERAND) ||
                 (awAddr == `BA_REG_ACC) || (awAddr == `BA_REG_AUX) ||
                 (awAddr == `BA_REG_FLAGS) || (awAddr == `BA_REG_DATA_POINTER);
  // writes while busy are refused so the running op keeps stable inputs
  wire wrOk = wrKnown && (state == BA_ST_IDLE);
  wire startOp = wrCmd && wrOk && wStrb[0];

  wire [11:0] ra = s_axi_araddr;
  wire raRam = (ra >= `BA_RAM_BASE) && (ra < 12'h300);
  wire [31:0] rdMux =
    raRam ? {24'h0, ram[{~ra[8], ra[7:2]}]} :
    (ra == `BA_REG_CMD) ? cmd :
    (ra == `BA_REG_OPERAND) ? {24'h0, operand} :
    (ra == `BA_REG_ACC) ? {24'h0, acc} :
    (ra == `BA_REG_AUX) ? {24'h0, aux} :
    (ra == `BA_REG_FLAGS) ? {24'h0, flags[7:1], parity} :
    (ra == `BA_REG_DATA_POINTER) ? {16'h0, data_pointer} :
    (ra == `BA_REG_STATUS) ? {30'h0, cmdErr, state == BA_ST_BUSY} :
    (ra == `BA_REG_RESULT) ? {24'h0, lastResult} : 32'h0;
  wire rdKnown = raRam || (ra <= `BA_REG_RESULT && ra[1:0] == 2'b00);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 12'h000;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrOk ? 2'b00 : 2'b10;
        awHeld <= 1'b0;
        wHeld <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdMux;
      s_axi_rresp <= rdKnown ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: result commits on the last cycle of the op's period
  wire lastCyc = (state == BA_ST_BUSY) && (cycCount == 10'h001);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= BA_ST_IDLE;
      cycCount <= 10'h000;
      aluBusy <= 1'b0;
      cmdErr <= 1'b0;
    end else begin
      unique case (state)
        BA_ST_IDLE: if (startOp) begin
          state <= BA_ST_BUSY;
          aluBusy <= 1'b1;
          cycCount <= 10'h000;
        end
        BA_ST_BUSY: begin
          if (cycCount == 10'h000) begin
            cycCount <= legalOp ? opCycles - 10'h001 : 10'h001; // [RULE2]
            cmdErr <= !legalOp;
            if (!legalOp || opCycles == 10'h001) begin
              state <= BA_ST_IDLE;
              aluBusy <= 1'b0;
            end
          end else if (lastCyc) begin
            state <= BA_ST_IDLE;
            aluBusy <= 1'b0;
            cycCount <= 10'h000;
          end else begin
            cycCount <= cycCount - 10'h001;
          end
        end
        default: state <= BA_ST_IDLE;
      endcase
    end
  end

  wire commit = lastCyc && legalOp;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cmd <= 32'h0000_0000;
      operand <= `BA_RST_BYTE;
      acc <= `BA_RST_BYTE;
      aux <= `BA_RST_BYTE;
      flags <= `BA_RST_BYTE;
      data_pointer <= `BA_RST_WORD;
      lastResult <= `BA_RST_BYTE;
    end else if (commit) begin
      acc <= next_acc;
      aux <= next_aux;
      flags <= next_flags;
      data_pointer <= next_data_pointer;
      lastResult <= memWrite ? next_mem : next_acc;
    end else if (doWrite && wrOk && wStrb[0]) begin
      unique case (awAddr)
        `BA_REG_CMD: cmd <= wData;
        `BA_REG_OPERAND: operand <= wData[7:0];
        `BA_REG_ACC: acc <= wData[7:0];
        `BA_REG_AUX: aux <= wData[7:0];
        `BA_REG_FLAGS: flags <= wData[7:0];
        `BA_REG_DATA_POINTER: data_pointer <= wStrb[1] ? wData[15:0] : {data_pointer[15:8], wData[7:0]};
        default: ;
      endcase
    end
  end

  // memory is not reset; software loads it before use
  always_ff @(posedge core_clk) begin
    if (commit && memWrite && memHit) begin
      ram[effAddr[6:0]] <= next_mem; // [RULE3]
    end else if (wrRam && wrOk && wStrb[0]) begin
      ram[wrRamIdx] <= wData[7:0];
    end
  end
endmodule
`default_nettype wire

// [hdl/ba_defines.svh]
`ifndef BA_DEFINES_SVH
`define BA_DEFINES_SVH

// timing: printed figures in ns, cycles derived from the 5 ns core clock
`define BA_CLK_PERIOD_NS 5
`define BA_T_SHORT_NS 1000
`define BA_T_DATA_POINTER_NS 2000
`define BA_T_MULDIV_NS 4000
`define BA_T_LOGIMM_NS 2000
`define BA_CYC_SHORT (`BA_T_SHORT_NS / `BA_CLK_PERIOD_NS)
`define BA_CYC_DATA_POINTER (`BA_T_DATA_POINTER_NS / `BA_CLK_PERIOD_NS)
`define BA_CYC_MULDIV (`BA_T_MULDIV_NS / `BA_CLK_PERIOD_NS)
`define BA_CYC_LOGIMM (`BA_T_LOGIMM_NS / `BA_CLK_PERIOD_NS)

// register file offsets (byte addresses)
`define BA_REG_CMD 12'h000
`define BA_REG_OPERAND 12'h004
`define BA_REG_ACC 12'h008
`define BA_REG_AUX 12'h00C
`define BA_REG_FLAGS 12'h010
`define BA_REG_DATA_POINTER 12'h014
`define BA_REG_STATUS 12'h018
`define BA_REG_RESULT 12'h01C
`define BA_RAM_BASE 12'h100

// command word fields
`define BA_CMD_OP_LSB 0
`define BA_CMD_MODE_LSB 8
`define BA_CMD_ADDR_LSB 16
`define BA_CMD_IMM_LSB 24

// flag bit positions in the flags word
`define BA_FLG_CY 7
`define BA_FLG_AC 6
`define BA_FLG_RS1 4
`define BA_FLG_RS0 3
`define BA_FLG_OV 2
`define BA_FLG_P 0

`define BA_RST_BYTE 8'h00
`define BA_RST_WORD 16'h0000

`endif

// [hdl/ba_pkg.sv]
package ba_pkg;
  typedef enum logic [4:0] {
    BA_ADD = 5'h00, BA_SUM_CARRY_OP = 5'h01, BA_MINUS_BORROW_OP = 5'h02, BA_INCA = 5'h03,
    BA_DECA = 5'h04, BA_INCM = 5'h05, BA_DECM = 5'h06, BA_INCDP = 5'h07,
    BA_MUL = 5'h08, BA_DIV = 5'h09, BA_DAA = 5'h0A, BA_ANDA = 5'h0B,
    BA_ORA = 5'h0C, BA_XORA = 5'h0D, BA_ANDM = 5'h0E, BA_ORM = 5'h0F,
    BA_XORM = 5'h10, BA_ANDMI = 5'h11, BA_ORMI = 5'h12, BA_XORMI = 5'h13,
    BA_CLR = 5'h14, BA_CPL = 5'h15, BA_RL = 5'h16, BA_RLC = 5'h17,
    BA_RR = 5'h18, BA_RRC = 5'h19, BA_SWAP = 5'h1A
  } ba_op_t;

  typedef enum logic [1:0] {
    BA_M_DIR = 2'h0, BA_M_IND = 2'h1, BA_M_REG = 2'h2, BA_M_IMM = 2'h3
  } ba_mode_t;

  typedef enum logic [1:0] {
    BA_ST_IDLE = 2'b01, BA_ST_BUSY = 2'b10
  } ba_state_t;
endpackage

// [verification/ba_alu_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module ba_alu_monitor (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic aluBusy
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////
  // busy stretches run to hundreds of cycles, too long for a repetition
  logic [10:0] busyCnt;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) busyCnt <= 11'h000;
    else if (aluBusy) busyCnt <= busyCnt + 11'h001;
    else busyCnt <= 11'h000;
  end
  sequence sOpStart;
    $rose(aluBusy);
  endsequence
  sequence sCmdAck;
    s_axi_bvalid && (s_axi_bresp == 2'h0);
  endsequence
  sequence sWriteTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  ////////////////////////////////////////////////////////////////
  AST_BUSY_LENGTH: assert property ($fell(aluBusy) |->
    busyCnt inside {[199:202], [399:402], [799:802]}) else $error("busy stretch length wrong");
  AST_OP_START: assert property (sOpStart |-> sCmdAck)
    else $error("op started without accepted command");
  AST_OP_HOLDS: assert property (sOpStart |-> aluBusy [*8])
    else $error("op ended too early");
  AST_BUSY_REFUSE: assert property ($rose(s_axi_bvalid) && $past(aluBusy) |->
    s_axi_bresp == 2'h2) else $error("write during busy not refused");
  // both halves are held for one cycle before the response is raised
  AST_WRITE_ANSWER: assert property (sWriteTaken |=> ##1 s_axi_bvalid)
    else $error("write response late");
  AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read response late");
  AST_B_TAKEN: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  AST_R_TAKEN: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  AST_READY_LOW: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready while response pending");
endmodule
bind byte_alu_arith_logic ba_alu_monitor i_ba_alu_monitor (
  .core_clk(core_clk),
  .rstn(rstn),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .aluBusy(aluBusy)
);
`default_nettype wire

// [verification/ba_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ba_host_model (
  input wire logic core_clk,
  output var logic [11:0] s_axi_awaddr,
  output var logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output var logic [31:0] s_axi_wdata,
  output var logic [3:0] s_axi_wstrb,
  output var logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output var logic s_axi_bready,
  output var logic [11:0] s_axi_araddr,
  output var logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output var logic s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
  end
  ////////////////////////////////////////////////////////////////
  // no cycle count is assumed; only the bench timeout ends a wait
  task automatic write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask
endmodule
`default_nettype wire

// [verification/byte_alu_arith_logic_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module byte_alu_arith_logic_bench;
  import ba_pkg::*;
  typedef struct packed {
    logic [7:0] op, imm, acc, aux, eAcc, eAux;
    logic cy, eCy, eOv, pad;
  } ba_row_t;
  localparam int LIMIT = 20000;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  logic coreClk = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, val;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, aluBusy;
  // op imm acc aux eAcc eAux {cy eCy eOv -}
  ba_row_t rows [25] = '{52'h00_20_10_00_30_00_8, 52'h01_20_10_00_31_00_8,
    52'h01_01_FF_00_00_00_4, 52'h00_70_70_00_E0_00_2, 52'h02_10_50_00_3F_00_8,
    52'h02_20_10_00_F0_00_4, 52'h0A_00_3C_00_42_00_0, 52'h0A_00_A0_00_00_00_4,
    52'h0B_53_35_00_11_00_C, 52'h0C_53_35_00_77_00_0, 52'h0D_53_35_00_66_00_0,
    52'h14_00_35_00_00_00_0, 52'h15_00_35_00_CA_00_0, 52'h16_00_81_00_03_00_0,
    52'h18_00_81_00_C0_00_0, 52'h17_00_81_00_02_00_4, 52'h17_00_40_00_81_00_8,
    52'h19_00_02_00_81_00_8, 52'h1A_00_35_00_53_00_0, 52'h03_00_FF_00_00_00_0,
    52'h04_00_00_00_FF_00_0, 52'h08_00_50_A0_00_32_A, 52'h08_00_0F_11_FF_00_0,
    52'h09_00_FB_12_0D_11_8, 52'h09_00_05_00_00_00_2};
  always #2.5 coreClk = ~coreClk;
  byte_alu_arith_logic i_byte_alu_arith_logic (.core_clk(coreClk), .rstn(rstn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .aluBusy(aluBusy));
  ba_host_model i_ba_host_model (.core_clk(coreClk),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  ////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    i_ba_host_model.write(a, d, resp);
    chk({30'h0, resp}, {30'h0, er});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hFFFFFFFF, input logic [1:0] er = 2'h0);
    i_ba_host_model.read(a, val, resp);
    chk(val & m, e);
    chk({30'h0, resp}, {30'h0, er});
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (aluBusy !== 1'b0 && n < 1000) begin
      @(posedge coreClk);
      #1;
      n++;
    end
    chk({31'h0, aluBusy}, 32'h0);
  endtask
  task automatic run(input logic [7:0] op, input logic [1:0] mode, input logic [7:0] adr,
                     input logic [7:0] imm);
    wr(12'h000, {imm, adr, 6'h00, mode, 3'h0, op[4:0]});
    #1;
    chk({31'h0, aluBusy}, 32'h1);
    wait_idle();
  endtask
  function automatic logic [11:0] ram(input int i);
    return 12'h100 + 12'(4 * i);
  endfunction
  ////////////////////////////////////////////////////////////////
  always @(posedge coreClk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (16) @(posedge coreClk);
    rstn <= 1'b1;
    for (int i = 0; i < 25; i++) begin
      wr(12'h010, {24'h0, rows[i].cy, 7'h0});
      wr(12'h008, {24'h0, rows[i].acc});
      wr(12'h00C, {24'h0, rows[i].aux});
      run(rows[i].op, (rows[i].op inside {8'h00, 8'h01, 8'h02, 8'h0B, 8'h0C, 8'h0D}) ? 2'h3 : 2'h0,
          8'h00, rows[i].imm);
      rd(12'h008, {24'h0, rows[i].eAcc});
      rd(12'h00C, {24'h0, rows[i].eAux});
      rd(12'h010, {24'h0, rows[i].eCy, 4'h0, rows[i].eOv, 1'b0, ^rows[i].eAcc}, 32'h85);
    end
    // bank two selected, working register three is byte 19
    wr(12'h010, 32'h10);
    wr(ram(19), 32'hFF);
    wr(ram(17), 32'h40);
    wr(ram(64), 32'h10);
    wr(12'h008, 32'h5A);
    run(8'h05, 2'h2, 8'h03, 8'h00);
    rd(ram(19), 32'h00, 32'hFF);
    run(8'h06, 2'h1, 8'h01, 8'h00);
    rd(ram(64), 32'h0F, 32'hFF);
    rd(12'h008, 32'h5A);
    wr(ram(32), 32'h0F);
    run(8'h00, 2'h0, 8'h20, 8'h00);
    rd(12'h008, 32'h69);
    run(8'h13, 2'h0, 8'h20, 8'hFF);
    rd(ram(32), 32'hF0, 32'hFF);
    run(8'h0F, 2'h0, 8'h20, 8'h00);
    rd(ram(32), 32'hF9, 32'hFF);
    rd(12'h01C, 32'hF9);
    rd(12'h008, 32'h69);
    wr(12'h014, 32'h00FF);
    run(8'h07, 2'h0, 8'h00, 8'h00);
    rd(12'h014, 32'h0100, 32'hFFFF);
    // a write landing in mid-operation must bounce and leave the result alone
    wr(12'h000, 32'h15);
    wr(12'h008, 32'h77, 2'h2);
    wait_idle();
    rd(12'h008, 32'h96);
    rd(12'h020, 32'h0, 32'hFFFFFFFF, 2'h2);
    // a reset while the alu is idle clears the registers but leaves the memory alone
    @(posedge coreClk);
    rstn <= 1'b0;
    repeat (2) @(posedge coreClk);
    rstn <= 1'b1;
    rd(12'h008, 32'h0);
    rd(12'h014, 32'h0);
    rd(12'h018, 32'h0);
    rd(ram(32), 32'hF9, 32'hFF);
    print_verdict();
  end
endmodule
`default_nettype wire
